//--- logic/holdoff_pkg.sv
// constants and types for the link hold-off control block
// Overview of operation
// [R1] While a port is held off its analog transmit and receive paths are switched off so no link forms.
// [R2] Hold-off leaves the port's digital side, register access and LEDs, running.
// [R3] The strap enables hold-off on every port at once and the per-port power-down bit enables it per port.
// [R4] A held-off port's transmitter and receiver sit in the software power-down state.
// [R5] The strap counts only when pulled high and is captured at hardware reset to set every port's default.
// [R6] Clearing bit 11 of a port's control register releases that port alone.
// [R7] A software reset via bit 15 reloads the port's power-down bit from the captured strap.
// [R8] Writing bit 11 set or clear enables or disables hold-off on that port whatever the strap.
// [R9] While management disable is active no port is held off.
// [R10] While management disable is active the management interface is shut off.
// [R11] Internal loopback keeps working during hold-off.
// [R12] After bit 11 clears the port resumes only once the power-down recovery time has passed.
// [R13] The strap is synchronised and latched at reset release and held until the next hardware reset.
package holdoff_pkg;
   localparam int NUM_PORTS = 8;
   localparam int CTRL_BIT_PWRDN = 11;
   localparam int CTRL_BIT_SWRST = 15;
   localparam int CTRL_BIT_LOOP = 14;
   localparam int CLOCK_MHZ = 250;
   localparam int RECOVERY_US = 1;
   localparam int RECOVERY_CYCLES = RECOVERY_US * CLOCK_MHZ;
   localparam int RECOV_W = 12;
   localparam logic [RECOV_W-1:0] RECOV_ZERO = 12'h000;
   localparam logic [RECOV_W-1:0] RECOV_ONE = 12'h001;

   typedef struct packed {
      logic write;
      logic [2:0] port;
      logic [15:0] data;
   } ctrl_write_t;
endpackage : holdoff_pkg

//--- logic/link_holdoff_control.sv
// per-port link hold-off control
`timescale 1ns/1ps
`default_nettype none
module link_holdoff_control #(
   parameter int PORTS = holdoff_pkg::NUM_PORTS,
   parameter int RECOVERY = holdoff_pkg::RECOVERY_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // pins
   input wire logic holdoff_strap_pin,
   input wire logic mgmt_disable_pin,
   // control register writes from management
   input wire holdoff_pkg::ctrl_write_t ctrl_wr,
   input wire logic [PORTS-1:0] loopback_req,
   // per-port state, management enable and latched strap
   output logic [PORTS-1:0] analog_off,
   output logic [PORTS-1:0] pwrdn_bit,
   output logic [PORTS-1:0] loopback_en,
   output logic [PORTS-1:0] digital_en,
   output logic mgmt_enable,
   output logic strap_latched
);
   import holdoff_pkg::*;

   // recovery reload and the cycle count a release may take
   localparam logic [RECOV_W-1:0] RECOV_RELOAD = RECOV_W'(RECOVERY - 1);
   localparam logic [RECOV_W-1:0] RECOV_COUNT = RECOV_W'(RECOVERY);

   // synchronisers and latched strap
   logic [1:0] strap_sync_q;
   logic [1:0] mdis_sync_q;
   logic strap_q;
   logic in_reset_q;
   logic mdis_s;
   // per-port state, management enable and write accept
   logic [PORTS-1:0] pwrdn_q;
   logic [PORTS-1:0] analog_off_q;
   logic [RECOV_W-1:0] recov_q [PORTS];
   logic [RECOV_W-1:0] rel_q [PORTS];
   logic [PORTS-1:0] loop_q;
   logic [PORTS-1:0] digital_q;
   logic mgmt_en_q;
   logic accept;

   // strap synchroniser
   always_ff @(posedge clock)
   begin
      strap_sync_q <= {strap_sync_q[0], holdoff_strap_pin};
   end

   // management disable synchroniser
   always_ff @(posedge clock)
   begin
      mdis_sync_q <= {mdis_sync_q[0], mgmt_disable_pin};
   end

   assign mdis_s = mdis_sync_q[1];

   // strap latched on the first edge after reset release
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         in_reset_q <= 1'b1;
         strap_q <= 1'b0;
      end
      else
      begin
         in_reset_q <= 1'b0;
         if (in_reset_q)
            strap_q <= strap_sync_q[1]; // [R5] [R13]
      end
   end

   // management interface gate
   always_ff @(posedge clock)
   begin
      if (rst)
         mgmt_en_q <= 1'b0;
      else
         mgmt_en_q <= ~mdis_s; // [R10]
   end

   // writes refused while management is disabled or the strap default loads
   assign accept = ctrl_wr.write & ~mdis_s & ~in_reset_q; // [R10]

   // loopback stays independent of hold-off
   always_ff @(posedge clock)
   begin
      if (rst)
         loop_q <= '0;
      else
         loop_q <= loopback_req; // [R11]
   end

   // digital side keeps running in every state
   always_ff @(posedge clock)
   begin
      if (rst)
         digital_q <= '1;
      else
         digital_q <= '1; // [R2]
   end

   // per-port power-down bit, analog power-down and checks
   for (genvar g = 0; g < PORTS; g++)
   begin : g_port
      localparam logic [2:0] PORT_ID = 3'(g);

      // power-down bit: strap default, soft reset or direct write
      always_ff @(posedge clock)
      begin
         if (rst)
            pwrdn_q[g] <= 1'b0;
         else if (in_reset_q)
            pwrdn_q[g] <= strap_sync_q[1]; // [R3] [R5]
         else if (accept && ctrl_wr.port == PORT_ID)
         begin
            if (ctrl_wr.data[CTRL_BIT_SWRST])
               pwrdn_q[g] <= strap_q; // [R7]
            else
               pwrdn_q[g] <= ctrl_wr.data[CTRL_BIT_PWRDN]; // [R6] [R8]
         end
      end

      // analog power-down with recovery delay on release
      always_ff @(posedge clock)
      begin
         if (rst)
         begin
            analog_off_q[g] <= 1'b1;
            recov_q[g] <= RECOV_ZERO;
         end
         else if (in_reset_q)
         begin
            analog_off_q[g] <= 1'b1; // [R1]
            recov_q[g] <= RECOV_ZERO;
         end
         else if (pwrdn_q[g] && !mdis_s)
         begin
            analog_off_q[g] <= 1'b1; // [R1] [R4] [R9]
            recov_q[g] <= RECOV_RELOAD;
         end
         else if (recov_q[g] != RECOV_ZERO)
         begin
            analog_off_q[g] <= 1'b1; // [R12]
            recov_q[g] <= recov_q[g] - RECOV_ONE;
         end
         else
         begin
            analog_off_q[g] <= 1'b0; // [R12]
            recov_q[g] <= RECOV_ZERO;
         end
      end

      // cycles a released port has stayed powered down, for the recovery check
      always_ff @(posedge clock)
      begin
         if (rst || in_reset_q || pwrdn_q[g] || !analog_off_q[g])
            rel_q[g] <= RECOV_ZERO;
         else
            rel_q[g] <= rel_q[g] + RECOV_ONE;
      end

      AST_PORT_HELD: assert property (@(posedge clock) disable iff (rst) // [R1] [R4]
         (pwrdn_q[g] && !mdis_s && !in_reset_q)
         |=> analog_off_q[g])
         else $error("held port not powered down");

      AST_PORT_MDIS: assert property (@(posedge clock) disable iff (rst) // [R9]
         (mdis_s && !in_reset_q && recov_q[g] == RECOV_ZERO)
         |=> !analog_off_q[g])
         else $error("hold-off applied under management disable");

      AST_PORT_RESUME: assert property (@(posedge clock) disable iff (rst) // [R12]
         (!pwrdn_q[g] && !in_reset_q && recov_q[g] == RECOV_ZERO)
         |=> !analog_off_q[g])
         else $error("released port still powered down");

      AST_PORT_RECOV: assert property (@(posedge clock) disable iff (rst) // [R12]
         (recov_q[g] != RECOV_ZERO)
         |=> analog_off_q[g])
         else $error("port resumed during recovery");

      AST_PORT_RECOV_LEN: assert property (@(posedge clock) disable iff (rst) // [R12]
         (rel_q[g] == RECOV_COUNT)
         |-> !analog_off_q[g])
         else $error("recovery lasted too long");

      AST_PORT_LOOP: assert property (@(posedge clock) disable iff (rst) // [R11]
         1'b1
         |=> loop_q[g] == $past(loopback_req[g]))
         else $error("loopback did not follow its request");

      AST_PORT_SWRST: assert property (@(posedge clock) disable iff (rst) // [R7]
         (accept && ctrl_wr.port == PORT_ID && ctrl_wr.data[CTRL_BIT_SWRST])
         |=> pwrdn_q[g] == strap_q)
         else $error("soft reset did not reload strap");

      AST_PORT_WRITE: assert property (@(posedge clock) disable iff (rst) // [R6] [R8]
         (accept && ctrl_wr.port == PORT_ID && !ctrl_wr.data[CTRL_BIT_SWRST])
         |=> pwrdn_q[g] == $past(ctrl_wr.data[CTRL_BIT_PWRDN]))
         else $error("power-down bit not written");

      AST_PORT_REFUSED: assert property (@(posedge clock) disable iff (rst) // [R10]
         (mdis_s && !in_reset_q)
         |=> $stable(pwrdn_q[g]))
         else $error("write taken under management disable");
   end

   assign analog_off = analog_off_q;
   assign pwrdn_bit = pwrdn_q;
   assign loopback_en = loop_q;
   assign digital_en = digital_q; // [R2]
   assign mgmt_enable = mgmt_en_q;
   assign strap_latched = strap_q;

   // block-level checks
   AST_OFF_WHEN_HELD: assert property (@(posedge clock) disable iff (rst) // [R1]
      (pwrdn_q[0] && !mdis_s)
      |=> analog_off_q[0])
      else $error("held port not powered down");

   AST_RELEASE_DELAY: assert property (@(posedge clock) disable iff (rst) // [R12]
      ($fell(pwrdn_q[0]) && !mdis_s)
      |-> analog_off_q[0] [*2])
      else $error("port resumed before recovery");

   AST_MDIS_NO_HOLD: assert property (@(posedge clock) disable iff (rst) // [R9]
      (mdis_s && !in_reset_q && recov_q[0] == RECOV_ZERO)
      |=> !analog_off_q[0])
      else $error("hold-off applied under management disable");

   AST_MDIS_MGMT: assert property (@(posedge clock) disable iff (rst) // [R10]
      mdis_s
      |=> !mgmt_en_q)
      else $error("management active while disabled");

   AST_MGMT_ON: assert property (@(posedge clock) disable iff (rst) // [R10]
      !mdis_s
      |=> mgmt_en_q)
      else $error("management off while enabled");

   AST_SWRST_STRAP: assert property (@(posedge clock) disable iff (rst) // [R7]
      (accept && ctrl_wr.port == 3'h0 && ctrl_wr.data[CTRL_BIT_SWRST])
      |=> pwrdn_q[0] == $past(strap_q))
      else $error("soft reset did not reload strap");

   AST_WRITE_BIT: assert property (@(posedge clock) disable iff (rst) // [R8]
      (accept && ctrl_wr.port == 3'h1 && !ctrl_wr.data[CTRL_BIT_SWRST])
      |=> pwrdn_q[1] == $past(ctrl_wr.data[CTRL_BIT_PWRDN]))
      else $error("power-down bit not written");

   AST_OTHER_PORT: assert property (@(posedge clock) disable iff (rst) // [R6]
      (accept && ctrl_wr.port == 3'h1)
      |=> $stable(pwrdn_q[0]))
      else $error("write disturbed another port");

   AST_STRAP_HOLD: assert property (@(posedge clock) disable iff (rst) // [R13]
      !in_reset_q
      |=> $stable(strap_q))
      else $error("latched strap changed");

   AST_STRAP_LATCH: assert property (@(posedge clock) disable iff (rst) // [R5] [R13]
      in_reset_q
      |=> strap_q == $past(strap_sync_q[1]))
      else $error("strap not captured at reset release");

   AST_LOOP: assert property (@(posedge clock) disable iff (rst) // [R11]
      loopback_req[0]
      |=> loop_q[0])
      else $error("loopback blocked");

   AST_STRAP_ALL: assert property (@(posedge clock) disable iff (rst) // [R3]
      in_reset_q
      |=> pwrdn_q == {PORTS{$past(strap_sync_q[1])}})
      else $error("strap default not on all ports");

   AST_RESET_QUIET: assert property (@(posedge clock) disable iff (rst) // [R1]
      in_reset_q
      |=> &analog_off_q)
      else $error("port powered up while strap default loads");

   AST_DIGITAL_ON: assert property (@(posedge clock) disable iff (rst) // [R2]
      1'b1
      |=> &digital_q)
      else $error("digital side switched off");

   // main scenarios
   COV_RELEASE: cover property (@(posedge clock) disable iff (rst) $fell(analog_off_q[0]));
   COV_SWRST: cover property (@(posedge clock) disable iff (rst)
      accept && ctrl_wr.data[CTRL_BIT_SWRST] && strap_q);
   COV_MDIS: cover property (@(posedge clock) disable iff (rst) mdis_s && pwrdn_q[0]);
   COV_SOFT_HOLD: cover property (@(posedge clock) disable iff (rst)
      accept && ctrl_wr.data[CTRL_BIT_PWRDN] && !ctrl_wr.data[CTRL_BIT_SWRST]);
   COV_LOOP_HELD: cover property (@(posedge clock) disable iff (rst) loop_q[0] && analog_off_q[0]);
endmodule : link_holdoff_control
`default_nettype wire

//--- tb/link_holdoff_control_tb.sv
// bench for the link hold-off control block
`timescale 1ns/1ps
`default_nettype none
module link_holdoff_control_tb;
   import holdoff_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic strap = 1'b0;
   logic mdis = 1'b0;
   logic [7:0] lb = 8'h00;
   ctrl_write_t cw;
   logic [7:0] aoff, pwr, lbe, dig;
   logic mg, sl;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   always #2 clock = ~clock;
   mgmt_model mgmt (.clock(clock), .ctrl_wr(cw));
   link_holdoff_control #(.PORTS(8), .RECOVERY(4)) dut (.clock(clock), .rst(rst), .holdoff_strap_pin(strap),
      .mgmt_disable_pin(mdis), .ctrl_wr(cw), .loopback_req(lb), .analog_off(aoff), .pwrdn_bit(pwr),
      .loopback_en(lbe), .digital_en(dig), .mgmt_enable(mg), .strap_latched(sl));
   task automatic give_verdict;
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic st(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask : st
   task automatic do_reset(input logic s);
      @(posedge clock);
      strap <= s;
      rst <= 1'b1;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      st(2);
   endtask : do_reset
   task automatic t_strap;
      do_reset(1'b1);
      chk("pwrdn", 8'hFF, pwr);
      chk("aoff", 8'hFF, aoff);
      chk("dig", 8'hFF, dig);
      chk("mgmt", 8'h01, {7'h00, mg});
      strap <= 1'b0;
      st(4);
      chk("latch", 8'h01, {7'h00, sl});
   endtask : t_strap
   task automatic t_release;
      mgmt.wr(3'h2, 16'h0000);
      st(0);
      chk("pwrdn", 8'hFB, pwr);
      st(2);
      chk("aoff", 8'hFF, aoff);
      st(4);
      chk("aoff", 8'hFB, aoff);
      lb <= 8'hA5;
      st(1);
      chk("loop", 8'hA5, lbe);
   endtask : t_release
   task automatic t_swrst;
      mgmt.wr(3'h2, 16'h8800);
      st(1);
      chk("pwrdn", 8'hFF, pwr);
      chk("aoff", 8'hFF, aoff);
   endtask : t_swrst
   task automatic t_mdis;
      mdis <= 1'b1;
      st(6);
      chk("mgmt", 8'h00, {7'h00, mg});
      chk("aoff", 8'h00, aoff);
      mgmt.wr(3'h0, 16'h0000);
      st(0);
      chk("pwrdn", 8'hFF, pwr);
      mdis <= 1'b0;
      st(4);
      chk("aoff", 8'hFF, aoff);
   endtask : t_mdis
   task automatic t_soft;
      do_reset(1'b0);
      chk("pwrdn", 8'h00, pwr);
      st(6);
      mgmt.wr(3'h5, 16'h0800);
      st(1);
      chk("pwrdn", 8'h20, pwr);
      chk("aoff", 8'h20, aoff);
   endtask : t_soft
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   initial
   begin
      t_strap();
      t_release();
      t_swrst();
      t_mdis();
      t_soft();
      give_verdict();
   end
endmodule : link_holdoff_control_tb
`default_nettype wire

//--- tb/mgmt_model.sv
// management controller model issuing control writes
`timescale 1ns/1ps
`default_nettype none
module mgmt_model (
   // clock
   input wire logic clock,
   // control writes
   output var holdoff_pkg::ctrl_write_t ctrl_wr
);
   import holdoff_pkg::*;
   initial ctrl_wr = '0;
   // one-cycle pulse; port, data and write are driven on the same edge
   task automatic wr(input logic [2:0] p, input logic [15:0] d);
      @(posedge clock);
      ctrl_wr <= '{write: 1'b1, port: p, data: d};
      @(posedge clock);
      ctrl_wr.write <= 1'b0;
   endtask : wr
endmodule : mgmt_model
`default_nettype wire
